//--- logic/sas_params.svh
// Offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// Register indices; byte address is four times the index
`define SAS_IDX_CTRL      8'hD2
`define SAS_IDX_RES_HI    8'hD3
`define SAS_IDX_RES_LO    8'hD4
`define SAS_IDX_IRQ_STAT  8'hD5
`define SAS_IDX_IRQ_MASK  8'hD6

// Control field positions
`define SAS_CHAN_MSB      7
`define SAS_CHAN_LSB      4
`define SAS_EOC_BIT       3
`define SAS_SPEED_MSB     2
`define SAS_SPEED_LSB     1
`define SAS_START_BIT     0

// Reset values and trial code preset at start
`define SAS_CTRL_RST      8'h00
`define SAS_MASK_RST      8'h00
`define SAS_SAR_MID       10'h200

// Converter clocks per phase
`define SAS_SETUP_CLKS    6'h0A
`define SAS_BIT_CLKS      6'h04

// System clocks per converter clock, by speed setting
`define SAS_DIV_SPD0      6'h10
`define SAS_DIV_SPD1      6'h08
`define SAS_DIV_SPD2      6'h04
`define SAS_DIV_SPD3      6'h20

// Bus responses
`define SAS_RESP_OKAY     2'h0
`define SAS_RESP_SLVERR   2'h2

`endif

//--- logic/sas_pkg.sv
// Types shared by the converter sequencer files
package sas_pkg;

    typedef enum logic [1:0] {
        SAS_ST_IDLE,
        SAS_ST_SETUP,
        SAS_ST_BIT
    } sas_state_e;

    typedef struct packed {
        logic [3:0] chan;
        logic       eoc;
        logic [1:0] speed;
        logic       start;
    } sas_ctrl_s;

    typedef struct packed {
        logic [7:0] hi;
        logic [1:0] lo;
    } sas_result_s;

endpackage

//--- logic/sas_clk_div.sv
// Converter clock tick generator from the system clock
`timescale 1ns/1ns
`include "sas_params.svh"
module sas_clk_div
    import sas_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [1:0] speed,
    output logic            tick
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] div;

    function automatic logic [5:0] speed_div(input logic [1:0] s);
        case (s)
            2'h0:    speed_div = `SAS_DIV_SPD0;
            2'h1:    speed_div = `SAS_DIV_SPD1;
            2'h2:    speed_div = `SAS_DIV_SPD2;
            default: speed_div = `SAS_DIV_SPD3;
        endcase
    endfunction

    always_comb begin
        div     = speed_div(speed);
        tick    = run && (cnt_r == div - 6'h01);
        cnt_nxt = cnt_r;
        if (!run || tick) begin
            cnt_nxt = 6'h00;
        end else begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_r <= 6'h00;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

//--- logic/sas_sar_seq.sv
// Successive-approximation sequencer: set-up phase then one bit per four ticks
`timescale 1ns/1ns
`include "sas_params.svh"
module sas_sar_seq
    import sas_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic        tick,
    input  wire logic        comp,
    output logic             idle,
    output logic [9:0]       code,
    output logic             done,
    output sas_result_s      result
);
    sas_state_e  state_r;
    sas_state_e  state_nxt;
    logic [5:0]  cnt_r;
    logic [5:0]  cnt_nxt;
    logic [3:0]  idx_r;
    logic [3:0]  idx_nxt;
    logic [9:0]  code_r;
    logic [9:0]  code_nxt;
    logic        done_r;
    logic        done_nxt;
    sas_result_s result_r;
    sas_result_s result_nxt;

    assign idle   = (state_r == SAS_ST_IDLE);
    assign code   = code_r;
    assign done   = done_r;
    assign result = result_r;

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        idx_nxt    = idx_r;
        code_nxt   = code_r;
        done_nxt   = 1'b0;
        result_nxt = result_r;
        case (state_r)
            SAS_ST_IDLE: begin
                if (start) begin
                    code_nxt  = `SAS_SAR_MID;
                    idx_nxt   = 4'h9;
                    cnt_nxt   = 6'h00;
                    state_nxt = SAS_ST_SETUP;
                end
            end
            SAS_ST_SETUP: begin
                if (tick) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == `SAS_SETUP_CLKS - 6'h01) begin
                        cnt_nxt   = 6'h00;
                        state_nxt = SAS_ST_BIT;
                    end
                end
            end
            SAS_ST_BIT: begin
                if (tick) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == `SAS_BIT_CLKS - 6'h01) begin
                        cnt_nxt = 6'h00;
                        // Drop the trial bit when input is below the trial level
                        code_nxt[idx_r] = comp;
                        if (idx_r == 4'h0) begin
                            result_nxt = code_nxt;
                            done_nxt   = 1'b1;
                            state_nxt  = SAS_ST_IDLE;
                        end else begin
                            code_nxt[idx_r - 4'h1] = 1'b1;
                            idx_nxt = idx_r - 4'h1;
                        end
                    end
                end
            end
            default: state_nxt = SAS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r  <= SAS_ST_IDLE;
            cnt_r    <= 6'h00;
            idx_r    <= 4'h0;
            code_r   <= 10'h000;
            done_r   <= 1'b0;
            result_r <= '0;
        end else if (ce) begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            idx_r    <= idx_nxt;
            code_r   <= code_nxt;
            done_r   <= done_nxt;
            result_r <= result_nxt;
        end
    end
endmodule

//--- logic/sas_adc_top.sv
// Converter sequencer top: AXI4-Lite registers, interrupt and conversion control
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "sas_params.svh"
module sas_adc_top
    import sas_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              comp_in,
    output logic [3:0]             ain_sel,
    output logic [9:0]             sar_code,
    output logic                   conv_busy,
    output logic                   irq
);
    // Register index from a byte address
    function automatic logic [ADDR_W-3:0] reg_idx(input logic [ADDR_W-1:0] a);
        reg_idx = a[ADDR_W-1:2];
    endfunction

    function automatic logic is_idx(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        is_idx = (reg_idx(a) == (ADDR_W-2)'(idx));
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = is_idx(a, `SAS_IDX_CTRL) || is_idx(a, `SAS_IDX_RES_HI)
                 || is_idx(a, `SAS_IDX_RES_LO) || is_idx(a, `SAS_IDX_IRQ_STAT)
                 || is_idx(a, `SAS_IDX_IRQ_MASK);
    endfunction

    // Bus state
    logic              aw_got_r;
    logic              aw_got_nxt;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [ADDR_W-1:0] aw_addr_nxt;
    logic              w_got_r;
    logic              w_got_nxt;
    logic [31:0]       w_data_r;
    logic [31:0]       w_data_nxt;
    logic [3:0]        w_strb_r;
    logic [3:0]        w_strb_nxt;
    logic              bvalid_r;
    logic              bvalid_nxt;
    logic [1:0]        bresp_r;
    logic [1:0]        bresp_nxt;
    logic              rvalid_r;
    logic              rvalid_nxt;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    logic [1:0]        rresp_r;
    logic [1:0]        rresp_nxt;

    // Register state
    sas_ctrl_s         ctrl_r;
    sas_ctrl_s         ctrl_nxt;
    sas_result_s       res_r;
    sas_result_s       res_nxt;
    logic              stat_r;
    logic              stat_nxt;
    logic              mask_r;
    logic              mask_nxt;
    logic [3:0]        conv_chan_r;
    logic [3:0]        conv_chan_nxt;

    // Comparator synchroniser
    logic              comp_meta_r;
    logic              comp_sync_r;

    // Handshake and write path helpers
    logic              aw_fire;
    logic              w_fire;
    logic              ar_fire;
    logic              wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;

    // Sequencer link
    logic              seq_idle;
    logic              seq_done;
    logic              seq_tick;
    logic              start_acc;
    logic [9:0]        seq_code;
    sas_result_s       seq_result;

    assign s_axi_awready = ce && !aw_got_r && !bvalid_r;
    assign s_axi_wready  = ce && !w_got_r && !bvalid_r;
    assign s_axi_arready = ce && !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire  = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_addr = aw_fire ? s_axi_awaddr : aw_addr_r;
    assign wr_data = w_fire ? s_axi_wdata : w_data_r;
    assign wr_strb = w_fire ? s_axi_wstrb : w_strb_r;
    assign wr_go   = (aw_got_r || aw_fire) && (w_got_r || w_fire);

    // Start is taken only while the sequencer is idle
    assign start_acc = ce && ctrl_r.start && seq_idle;

    assign ain_sel   = conv_chan_r;
    assign sar_code  = seq_code;
    assign conv_busy = !seq_idle;
    assign irq       = stat_r && mask_r;

    always_comb begin
        aw_got_nxt    = aw_got_r;
        aw_addr_nxt   = aw_addr_r;
        w_got_nxt     = w_got_r;
        w_data_nxt    = w_data_r;
        w_strb_nxt    = w_strb_r;
        bvalid_nxt    = bvalid_r;
        bresp_nxt     = bresp_r;
        rvalid_nxt    = rvalid_r;
        rdata_nxt     = rdata_r;
        rresp_nxt     = rresp_r;
        ctrl_nxt      = ctrl_r;
        res_nxt       = res_r;
        stat_nxt      = stat_r;
        mask_nxt      = mask_r;
        conv_chan_nxt = conv_chan_r;

        if (aw_fire) begin
            aw_got_nxt  = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (w_fire) begin
            w_got_nxt  = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end

        // Accepting a start latches the channel for the whole conversion
        if (start_acc) begin
            ctrl_nxt.start = 1'b0;
            conv_chan_nxt  = ctrl_r.chan;
        end

        if (wr_go) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = is_mapped(wr_addr) ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
            if (wr_strb[0]) begin
                if (is_idx(wr_addr, `SAS_IDX_CTRL)) begin
                    ctrl_nxt.chan  = wr_data[`SAS_CHAN_MSB:`SAS_CHAN_LSB];
                    ctrl_nxt.speed = wr_data[`SAS_SPEED_MSB:`SAS_SPEED_LSB];
                    if (wr_data[`SAS_START_BIT]) begin
                        ctrl_nxt.start = 1'b1;
                        ctrl_nxt.eoc   = 1'b0;
                    end
                end else if (is_idx(wr_addr, `SAS_IDX_IRQ_MASK)) begin
                    mask_nxt = wr_data[0];
                end
            end
        end

        if (ar_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = is_mapped(s_axi_araddr) ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
            rdata_nxt  = 32'h0000_0000;
            if (is_idx(s_axi_araddr, `SAS_IDX_CTRL)) begin
                rdata_nxt[7:0] = ctrl_r;
            end else if (is_idx(s_axi_araddr, `SAS_IDX_RES_HI)) begin
                rdata_nxt[7:0] = res_r.hi;
            end else if (is_idx(s_axi_araddr, `SAS_IDX_RES_LO)) begin
                rdata_nxt[1:0] = res_r.lo;
            end else if (is_idx(s_axi_araddr, `SAS_IDX_IRQ_STAT)) begin
                rdata_nxt[0] = stat_r;
                stat_nxt     = 1'b0;
            end else if (is_idx(s_axi_araddr, `SAS_IDX_IRQ_MASK)) begin
                rdata_nxt[0] = mask_r;
            end
        end

        // Completion wins over a status read clear in the same cycle
        // Flag stays low while a newer start waits or is being written
        if (seq_done) begin
            res_nxt      = seq_result;
            ctrl_nxt.eoc = !(ctrl_r.start || ctrl_nxt.start);
            stat_nxt     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aw_got_r    <= 1'b0;
            aw_addr_r   <= '0;
            w_got_r     <= 1'b0;
            w_data_r    <= 32'h0000_0000;
            w_strb_r    <= 4'h0;
            bvalid_r    <= 1'b0;
            bresp_r     <= `SAS_RESP_OKAY;
            rvalid_r    <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            rresp_r     <= `SAS_RESP_OKAY;
            ctrl_r      <= `SAS_CTRL_RST;
            res_r       <= '0;
            stat_r      <= 1'b0;
            mask_r      <= 1'b0;
            conv_chan_r <= 4'h0;
        end else if (ce) begin
            aw_got_r    <= aw_got_nxt;
            aw_addr_r   <= aw_addr_nxt;
            w_got_r     <= w_got_nxt;
            w_data_r    <= w_data_nxt;
            w_strb_r    <= w_strb_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            ctrl_r      <= ctrl_nxt;
            res_r       <= res_nxt;
            stat_r      <= stat_nxt;
            mask_r      <= mask_nxt;
            conv_chan_r <= conv_chan_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end else if (ce) begin
            comp_meta_r <= comp_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    sas_clk_div u_div (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .run     (!seq_idle),
        .speed   (ctrl_r.speed),
        .tick    (seq_tick)
    );

    sas_sar_seq u_seq (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .start   (start_acc),
        .tick    (seq_tick),
        .comp    (comp_sync_r),
        .idle    (seq_idle),
        .code    (seq_code),
        .done    (seq_done),
        .result  (seq_result)
    );
endmodule

//--- tb/sas_adc_properties.sv
// Bus handshake and conversion sequencing properties of the sequencer top
`timescale 1ns/1ns
`include "sas_params.svh"
module sas_adc_properties
    import sas_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [3:0]        ain_sel,
    input wire logic [9:0]        sar_code,
    input wire logic              conv_busy,
    input wire logic              irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [11:0] busy_len_r;
    logic        wr_go;
    logic        st_go;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign st_go = wr_go && s_axi_wstrb[0] && s_axi_wdata[0]
        && (s_axi_awaddr == ADDR_W'({`SAS_IDX_CTRL, 2'b00}));
    // Busy length, cleared whenever idle
    always_ff @(posedge sys_clk) begin
        if (reset || !conv_busy)
            busy_len_r <= 12'h000;
        else
            busy_len_r <= busy_len_r + 12'h001;
    end
    AST_WR_RESP: assert property (wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    AST_START_BUSY: assert property (st_go && !conv_busy |-> ##[1:3] conv_busy)
        else $error("start did not begin a conversion");
    AST_PRESET: assert property ($rose(conv_busy) |-> sar_code == `SAS_SAR_MID)
        else $error("trial code not mid-scale at start");
    AST_CONV_LEN: assert property ($fell(conv_busy) |-> busy_len_r inside {[196:1606]})
        else $error("conversion length out of range");
    AST_CHAN_HOLD: assert property (conv_busy ##1 conv_busy |-> $stable(ain_sel))
        else $error("channel moved during conversion");
    AST_IDLE_QUIET: assert property (!conv_busy [*3] |-> $stable(sar_code))
        else $error("trial code moved while idle");
    COV_DONE: cover property ($fell(conv_busy));
    COV_IRQ: cover property ($rose(irq));
    COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == `SAS_RESP_SLVERR);
endmodule

bind sas_adc_top sas_adc_properties #(.ADDR_W(ADDR_W)) u_props (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ain_sel(ain_sel), .sar_code(sar_code),
    .conv_busy(conv_busy), .irq(irq));

//--- tb/sas_comp_model.sv
// Analog input mux and comparator model facing the converter
`timescale 1ns/1ns
module sas_comp_model (
    input  wire logic [15:0][9:0] levels,
    input  wire logic [3:0]       ain_sel,
    input  wire logic [9:0]       sar_code,
    output logic                  comp_in
);
    // Settles shortly after the trial code, unsynchronised
    assign #2 comp_in = levels[ain_sel] >= sar_code;
endmodule

//--- tb/sas_adc_top_tb_top.sv
// Register-level bench for the converter sequencer top
`timescale 1ns/1ns
`include "sas_params.svh"
module sas_adc_top_tb_top;
    import sas_pkg::*;
    localparam logic [11:0] A_CTRL = {2'b00, `SAS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_HI   = {2'b00, `SAS_IDX_RES_HI, 2'b00};
    localparam logic [11:0] A_LO   = {2'b00, `SAS_IDX_RES_LO, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `SAS_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, `SAS_IDX_IRQ_MASK, 2'b00};
    localparam logic [1:0]  OK     = `SAS_RESP_OKAY;
    localparam logic [1:0]  ERR    = `SAS_RESP_SLVERR;
    logic             sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]      awaddr, araddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [15:0][9:0] lvl;
    logic             awready, wready, bvalid, arready, rvalid, comp, busy, irq;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    logic [3:0]       ain_sel;
    logic [9:0]       sar_code;
    int               error_cnt, total_checks, busy_cyc, i;

    sas_adc_top uut (.sys_clk(sys_clk), .reset(reset), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp_in(comp), .ain_sel(ain_sel), .sar_code(sar_code),
        .conv_busy(busy), .irq(irq));
    sas_comp_model u_comp (.levels(lvl), .ain_sel(ain_sel), .sar_code(sar_code),
        .comp_in(comp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk({bvalid, 29'h0, bresp}, {1'b1, 29'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        chk({rvalid, 29'h0, rresp}, {1'b1, 29'h0, er});
        chk(rdata, ed);
    endtask

    task automatic conv(input logic [3:0] ch, input logic [1:0] sp);
        int n, d;
        d = sp == 2'b00 ? `SAS_DIV_SPD0 : sp == 2'b01 ? `SAS_DIV_SPD1 :
            sp == 2'b10 ? `SAS_DIV_SPD2 : `SAS_DIV_SPD3;
        wr(A_CTRL, {ch, 1'b0, sp, 1'b1}, OK);
        busy_cyc = 0;
        rd(A_CTRL, {24'h0, ch, 1'b0, sp, 1'b0}, OK);
        chk({27'h0, busy, ain_sel}, {27'h0, 1'b1, ch});
        wr(A_CTRL, {~ch, 1'b0, sp, 1'b0}, OK);
        chk({28'h0, ain_sel}, {28'h0, ch});
        for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, busy_cyc inside {[50 * d - 2:50 * d + 3]}}, 32'h1);
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge sys_clk) if (busy === 1'b1) busy_cyc <= busy_cyc + 1;

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        for (i = 0; i < 16; i++) lvl[i] = 10'(i * 67 + 5);
        lvl[0] = 10'h000;
        lvl[15] = 10'h3FF;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd(A_CTRL, 32'h0, OK);
        rd(A_HI, 32'h0, OK);
        rd(A_LO, 32'h0, OK);
        rd(A_STAT, 32'h0, OK);
        rd(A_MASK, 32'h0, OK);
        rd(12'h000, 32'h0, ERR);
        wr(12'h000, 8'h5A, ERR);
        wr(A_CTRL, 8'hA4, OK);
        rd(A_CTRL, 32'hA4, OK);
        wr(A_CTRL, 8'hAC, OK);
        rd(A_CTRL, 32'hA4, OK);
        wstrb <= 4'h0;
        wr(A_CTRL, 8'h13, OK);
        wstrb <= 4'hF;
        rd(A_CTRL, 32'hA4, OK);
        chk({31'h0, busy}, 32'h0);
        wr(A_HI, 8'h55, OK);
        rd(A_HI, 32'h0, OK);
        for (i = 0; i < 16; i++) begin
            wr(A_MASK, {7'h0, i[0]}, OK);
            conv(i[3:0], i[1:0]);
            chk({31'h0, irq}, {31'h0, i[0]});
            rd(A_CTRL, {24'h0, ~i[3:0], 1'b1, i[1:0], 1'b0}, OK);
            rd(A_HI, {24'h0, lvl[i][9:2]}, OK);
            rd(A_LO, {30'h0, lvl[i][1:0]}, OK);
            rd(A_STAT, 32'h1, OK);
            rd(A_STAT, 32'h0, OK);
            chk({31'h0, irq}, 32'h0);
        end
        conv(4'h3, 2'b10);
        conv(4'h5, 2'b10);
        rd(A_HI, {24'h0, lvl[5][9:2]}, OK);
        rd(A_LO, {30'h0, lvl[5][1:0]}, OK);
        wr(A_CTRL, 8'h75, OK);
        wr(A_CTRL, 8'h75, OK);
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge sys_clk);
        rd(A_CTRL, 32'h74, OK);
        chk({31'h0, busy}, 32'h1);
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge sys_clk);
        rd(A_CTRL, 32'h7C, OK);
        rd(A_HI, {24'h0, lvl[7][9:2]}, OK);
        wrap_up();
    end
endmodule
